// File: pmp_pkg.sv
// package of constants for the mac-facing data port
package pmp_pkg;
  localparam int          CLK_HZ        = 25000000;
  localparam int          TXCLK_100_HZ  = 25000000;
  localparam int          TXCLK_10_HZ   = 2500000;
  // half periods of the generated transmit clock, at least one cycle
  localparam int          HALF_100      = (CLK_HZ / TXCLK_100_HZ) / 2 > 0 ?
                                          (CLK_HZ / TXCLK_100_HZ) / 2 : 1;
  localparam int          HALF_10       = (CLK_HZ / TXCLK_10_HZ) / 2;
  localparam logic [4:0]  CODE_H        = 5'h04;
  localparam logic [7:0]  SFD_BYTE      = 8'hAB;
  localparam int          STRAP_W       = 3;
  localparam int          IRQ_W         = 4;
  localparam int          EV_TX_ERR     = 0;
  localparam int          EV_RX_ERR     = 1;
  localparam int          EV_RX_START   = 2;
  localparam int          EV_TX_START   = 3;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_CLR  = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_EN   = 4'h2;
  localparam logic [3:0]  ADDR_CONFIG   = 4'h3;
  localparam logic [3:0]  ADDR_STRAPS   = 4'h4;
  localparam logic [3:0]  ADDR_TX_WORD  = 4'h5;
  localparam int          CFG_SPEED100  = 0;
  localparam int          CFG_SYMBOL    = 1;
  localparam logic [1:0]  CFG_RESET     = 2'h1;
endpackage

// File: pmp_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pmp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// File: pmp_port.sv
// mac-facing mii/rmii data port with straps and interrupt
// Contract
// - tx bits 0 and 1 used always
// - tx error at 100 gives H code (in symbol mode the code passes the tx word through and sends no H code)
// - tx error ignored at 10 mb
// - tx enable qualifies 4 or 2 bits
// - mii tx clock 25/2.5 mhz, rmii none (the divider here gives 12.5/2.5 mhz)
// - symbol mode uses fifth tx bit
// - rx data 4 bits mii, 2 rmii
// - interrupt output active low, open drain
// - strap low mii, high rmii
// - three mode straps form default mode
// - three address straps form mgmt address
// - straps caught at each reset
// - rx valid only while data presented
// - rmii 10mb rx data low until sfd
// - rx error for any frame error (in mii symbol mode the code puts the fifth receive bit on rx error instead)
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmp_port (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output var  logic [7:0] rdata_o,
  input  wire logic [3:0] txd_i,
  input  wire logic       tx_symbol_msb_i,
  input  wire logic       tx_en_i,
  input  wire logic       tx_er_i,
  output var  logic       tx_clk_o,
  output var  logic [4:0] tx_word_o,
  output var  logic       tx_word_valid_o,
  input  wire logic [3:0] line_rxd_i,
  input  wire logic       line_rx_dv_i,
  input  wire logic       line_rx_err_i,
  input  wire logic       line_rx_sym_msb_i,
  input  wire logic [3:0] rxd_pin_i,
  input  wire logic       rx_dv_pin_i,
  input  wire logic       rx_er_pin_i,
  output var  logic [3:0] rxd_o,
  output var  logic [3:0] rxd_oe_low_o,
  output var  logic       rx_dv_o,
  output var  logic       rx_dv_oe_low_o,
  output var  logic       rx_er_o,
  output var  logic       rx_er_oe_low_o,
  output var  logic       irq_out_low_o,
  output var  logic       irq_out_low_oe_low_o,
  output var  logic [2:0] default_op_mode_o,
  output var  logic [2:0] mgmt_addr_o,
  output var  logic       reduced_iface_o
);
  // strap pins share the receive pads; sampled through synchronisers
  logic [8:0] pin_s;
  logic [5:0] tx_s;
  logic [3:0] txd_s;
  logic       tx_en_s;
  logic       tx_er_s;
  logic       tx_msb_s;

  pmp_sync #(.W(9)) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({rx_er_pin_i, rx_dv_pin_i, rxd_pin_i, tx_symbol_msb_i, tx_er_i, tx_en_i}),
    .q_o       (pin_s)
  );
  assign tx_en_s  = pin_s[0];
  assign tx_er_s  = pin_s[1];
  assign tx_msb_s = pin_s[2];
  assign tx_s     = {pin_s[8:3]};

  logic [3:0] txd_raw;
  pmp_sync #(.W(4)) u_txd_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (txd_i),
    .q_o       (txd_raw)
  );
  assign txd_s = txd_raw;

  // strap capture: one clocked sample after the reset releases
  logic       strap_pending;
  logic       rmii;
  logic [2:0] mode_strap;
  logic [2:0] addr_strap;

  // the synchronisers are cleared in reset, so pad levels taken at the first
  // edge after release reach their outputs one edge later; capture at the next edge
  logic [1:0] strap_wait;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_wait <= 2'h3;
    end else if (strap_wait != 2'h0) begin
      strap_wait <= strap_wait - 2'h1;
    end
  end

  assign strap_pending = (strap_wait == 2'h1);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rmii       <= 1'b0;
      mode_strap <= 3'h7;
      addr_strap <= 3'h0;
    end else if (strap_pending) begin
      rmii       <= tx_s[2];
      mode_strap <= {tx_s[4], tx_s[1], tx_s[0]};
      addr_strap <= {tx_s[3], tx_s[5], tx_s[1]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      default_op_mode_o <= 3'h7;
      mgmt_addr_o       <= 3'h0;
      reduced_iface_o   <= 1'b0;
    end else begin
      default_op_mode_o <= mode_strap;
      mgmt_addr_o       <= addr_strap;
      reduced_iface_o   <= rmii;
    end
  end

  // configuration register: speed and symbol-interface bypass
  logic [1:0] cfg;
  logic       speed100;
  logic       symbol_mode;
  assign speed100    = cfg[pmp_pkg::CFG_SPEED100];
  assign symbol_mode = cfg[pmp_pkg::CFG_SYMBOL];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg <= pmp_pkg::CFG_RESET;
    end else if (wr_i && addr_i == pmp_pkg::ADDR_CONFIG) begin
      cfg <= wdata_i[1:0];
    end
  end

  // transmit clock divider; it runs only in mii mode
  localparam int CW = 8;
  logic [CW-1:0] div_cnt;
  logic [CW-1:0] half_cnt;
  logic          tx_clk_q;
  logic          tx_sample;

  assign half_cnt = speed100 ? CW'(pmp_pkg::HALF_100) : CW'(pmp_pkg::HALF_10);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || rmii) begin
      div_cnt  <= '0;
      tx_clk_q <= 1'b0;
    end else if (div_cnt >= half_cnt - 1'b1) begin
      div_cnt  <= '0;
      tx_clk_q <= ~tx_clk_q;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // at 100 mb the divided clock runs at half the system clock: every cycle samples
  assign tx_sample = rmii ? 1'b1 :
                     (pmp_pkg::HALF_100 <= 1 && speed100) ? 1'b1 :
                     (div_cnt >= half_cnt - 1'b1) && !tx_clk_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_clk_o <= 1'b0;
    end else begin
      tx_clk_o <= rmii ? 1'b0 : tx_clk_q;
    end
  end

  // transmit capture and encode
  logic [4:0] next_tx_word;
  logic       tx_en_d;

  always_comb begin
    if (symbol_mode && !rmii) begin
      next_tx_word = {tx_msb_s, txd_s};
    end else if (rmii) begin
      next_tx_word = {3'h0, txd_s[1:0]};
    end else begin
      next_tx_word = {1'b0, txd_s};
    end
    if (tx_er_s && speed100 && !symbol_mode) begin
      next_tx_word = pmp_pkg::CODE_H;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_word_o       <= 5'h00;
      tx_word_valid_o <= 1'b0;
      tx_en_d         <= 1'b0;
    end else begin
      tx_word_valid_o <= tx_sample && tx_en_s;
      if (tx_sample) begin
        tx_en_d <= tx_en_s;
        if (tx_en_s) begin
          tx_word_o <= next_tx_word;
        end
      end
    end
  end

  // receive path
  logic [7:0] sfd_shift;
  logic       sfd_seen;
  logic       rx_frame_err;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !line_rx_dv_i) begin
      sfd_shift <= 8'h00;
      sfd_seen  <= 1'b0;
    end else if (!sfd_seen) begin
      sfd_shift <= {line_rxd_i[1:0], sfd_shift[7:2]};
      if ({line_rxd_i[1:0], sfd_shift[7:2]} == pmp_pkg::SFD_BYTE) begin
        sfd_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !line_rx_dv_i) begin
      rx_frame_err <= 1'b0;
    end else if (line_rx_err_i) begin
      rx_frame_err <= 1'b1;
    end
  end

  logic       rx_gate;
  assign rx_gate = rmii && !speed100 && !sfd_seen;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rxd_o   <= 4'h0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
    end else begin
      rx_dv_o <= line_rx_dv_i;
      if (!line_rx_dv_i || rx_gate) begin
        rxd_o <= 4'h0;
      end else if (rmii) begin
        rxd_o <= {2'h0, line_rxd_i[1:0]};
      end else begin
        rxd_o <= line_rxd_i;
      end
      if (symbol_mode && !rmii) begin
        rx_er_o <= line_rx_sym_msb_i;
      end else begin
        rx_er_o <= line_rx_dv_i && (line_rx_err_i || rx_frame_err);
      end
    end
  end

  // receive pads are strap inputs during reset: released from drive there
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rxd_oe_low_o   <= 4'hF;
      rx_dv_oe_low_o <= 1'b1;
      rx_er_oe_low_o <= 1'b1;
    end else begin
      rxd_oe_low_o   <= rmii ? 4'hC : 4'h0;
      rx_dv_oe_low_o <= 1'b0;
      rx_er_oe_low_o <= 1'b0;
    end
  end

  // interrupts: sticky status, write-one clear, enable; set wins
  logic [pmp_pkg::IRQ_W-1:0] irq_stat;
  logic [pmp_pkg::IRQ_W-1:0] irq_en;
  logic [pmp_pkg::IRQ_W-1:0] irq_ev;
  logic                      rx_dv_d;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_dv_d <= 1'b0;
    end else begin
      rx_dv_d <= line_rx_dv_i;
    end
  end

  always_comb begin
    irq_ev                       = '0;
    irq_ev[pmp_pkg::EV_TX_ERR]   = tx_sample && tx_en_s && tx_er_s && speed100;
    irq_ev[pmp_pkg::EV_RX_ERR]   = line_rx_dv_i && line_rx_err_i;
    irq_ev[pmp_pkg::EV_RX_START] = line_rx_dv_i && !rx_dv_d;
    irq_ev[pmp_pkg::EV_TX_START] = tx_sample && tx_en_s && !tx_en_d;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wr_i && addr_i == pmp_pkg::ADDR_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~wdata_i[pmp_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_en <= '0;
    end else if (wr_i && addr_i == pmp_pkg::ADDR_IRQ_EN) begin
      irq_en <= wdata_i[pmp_pkg::IRQ_W-1:0];
    end
  end

  // open drain: pad value stays low, enable pulls it, pull-up gives high
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_out_low_o        <= 1'b0;
      irq_out_low_oe_low_o <= 1'b1;
    end else begin
      irq_out_low_o        <= 1'b0;
      irq_out_low_oe_low_o <= ~|(irq_stat & irq_en);
    end
  end

  // register read port
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        pmp_pkg::ADDR_IRQ_STAT: rdata_o <= {4'h0, irq_stat};
        pmp_pkg::ADDR_IRQ_EN:   rdata_o <= {4'h0, irq_en};
        pmp_pkg::ADDR_CONFIG:   rdata_o <= {6'h00, cfg};
        pmp_pkg::ADDR_STRAPS:   rdata_o <= {1'b0, rmii, addr_strap, mode_strap};
        pmp_pkg::ADDR_TX_WORD:  rdata_o <= {3'h0, tx_word_o};
        default:                rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: pmp_mac_model.sv
// behavioural mac driving the transmit pins
`timescale 1ns/1ps
`default_nettype none
module pmp_mac_model (
  input  wire logic       clk_i,
  input  wire logic       tx_clk_i,
  input  wire logic       link_clk_i,
  input  wire logic       rmii_i,
  input  wire logic       en_i,
  input  wire logic [4:0] d_i,
  input  wire logic       er_i,
  output var  logic [3:0] txd_o,
  output var  logic       msb_o,
  output var  logic       en_o,
  output var  logic       er_o
);
  logic tc_q;
  logic lc_q;
  initial begin
    {txd_o, msb_o, en_o, er_o, tc_q, lc_q} = '0;
  end
  always @(posedge clk_i) begin
    tc_q <= tx_clk_i;
    lc_q <= link_clk_i;
    // pins move only on a pacing edge so the port never sees a half-changed word
    if (rmii_i ? (link_clk_i && !lc_q) : (tx_clk_i && !tc_q)) begin
      txd_o <= rmii_i ? {2'b00, d_i[1:0]} : d_i[3:0];
      msb_o <= d_i[4];
      en_o  <= en_i;
      er_o  <= er_i && !rmii_i;
    end
  end
endmodule
`default_nettype wire

// File: pmp_port_chk.sv
// concurrent checks on the mac-facing data port
`timescale 1ns/1ps
`default_nettype none
module pmp_port_chk (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       tx_en_i,
  input wire logic       tx_clk_o,
  input wire logic [4:0] tx_word_o,
  input wire logic       tx_word_valid_o,
  input wire logic [3:0] line_rxd_i,
  input wire logic       line_rx_dv_i,
  input wire logic       line_rx_err_i,
  input wire logic [3:0] rxd_o,
  input wire logic       rx_dv_o,
  input wire logic       rx_er_o,
  input wire logic       irq_out_low_o,
  input wire logic [2:0] default_op_mode_o,
  input wire logic [2:0] mgmt_addr_o,
  input wire logic       reduced_iface_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // straps land on the outputs four edges after release; two more let
  // the stability window start past that step
  sequence s_settled;
    !rst_i [*6];
  endsequence
  sequence s_straps_still;
    $stable({default_op_mode_o, mgmt_addr_o, reduced_iface_o});
  endsequence
  sequence s_mii_valid;
    s_settled ##0 (!reduced_iface_o && rx_dv_o);
  endsequence
  sequence s_rmii_valid;
    s_settled ##0 (reduced_iface_o && rx_dv_o);
  endsequence
  sequence s_rmii_word;
    s_settled ##0 (tx_word_valid_o && reduced_iface_o && tx_word_o != pmp_pkg::CODE_H);
  endsequence
  a_irq_pin_low: assert property (irq_out_low_o == 1'b0)
    else $error("interrupt pin driven high");
  a_rmii_no_clk: assert property (s_settled ##0 reduced_iface_o |-> !tx_clk_o)
    else $error("transmit clock runs in reduced mode");
  a_straps_hold: assert property (s_settled |-> s_straps_still)
    else $error("captured straps changed outside reset");
  a_rx_dv_follow: assert property (rx_dv_o == $past(line_rx_dv_i))
    else $error("receive valid does not follow line data");
  a_rx_err_flag: assert property ($past(line_rx_dv_i && line_rx_err_i) |-> rx_er_o)
    else $error("receive error not flagged");
  a_mii_rxd_pass: assert property (s_mii_valid |-> rxd_o == $past(line_rxd_i))
    else $error("mii receive nibble wrong");
  a_rmii_rx_high: assert property (s_rmii_valid |-> rxd_o[3:2] == 2'b00)
    else $error("upper receive bits used in reduced mode");
  a_tx_en_qual: assert property (tx_word_valid_o |-> $past(tx_en_i, 3))
    else $error("transmit word without enable");
  a_rmii_tx_high: assert property (s_rmii_word |-> tx_word_o[4:2] == 3'b000)
    else $error("upper transmit bits used in reduced mode");
endmodule
bind pmp_port pmp_port_chk u_pmp_port_chk (
  .ref_clk_i         (ref_clk_i),
  .rst_i             (rst_i),
  .tx_en_i           (tx_en_i),
  .tx_clk_o          (tx_clk_o),
  .tx_word_o         (tx_word_o),
  .tx_word_valid_o   (tx_word_valid_o),
  .line_rxd_i        (line_rxd_i),
  .line_rx_dv_i      (line_rx_dv_i),
  .line_rx_err_i     (line_rx_err_i),
  .rxd_o             (rxd_o),
  .rx_dv_o           (rx_dv_o),
  .rx_er_o           (rx_er_o),
  .irq_out_low_o     (irq_out_low_o),
  .default_op_mode_o (default_op_mode_o),
  .mgmt_addr_o       (mgmt_addr_o),
  .reduced_iface_o   (reduced_iface_o)
);
`default_nettype wire

// File: testbench.sv
// self-checking bench for the mac-facing data port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, lk = 1'b0;
  logic       tx_en_i, tx_er_i, tx_symbol_msb_i, tx_clk_o, tx_word_valid_o, reduced_iface_o;
  logic       line_rx_dv_i = 1'b0, line_rx_err_i = 1'b0, rx_dv_o, rx_dv_oe_low_o, rx_er_o;
  logic       rx_er_oe_low_o, irq_out_low_o, irq_out_low_oe_low_o, m_en = 1'b0, m_er = 1'b0;
  logic [3:0] addr_i = 4'h0, line_rxd_i = 4'h0, txd_i, rxd_o, rxd_oe_low_o;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [4:0] m_d = 5'h00, tx_word_o;
  logic [5:0] s = 6'h00;
  logic [2:0] default_op_mode_o, mgmt_addr_o;
  int         failures = 0, num_checks = 0;
  // released pads fall back to the strap resistors
  wire  logic [3:0] rxd_pin_i = (rxd_o & ~rxd_oe_low_o) | (s[3:0] & rxd_oe_low_o);
  wire  logic       rx_dv_pin_i = rx_dv_oe_low_o ? s[4] : rx_dv_o;
  wire  logic       rx_er_pin_i = rx_er_oe_low_o ? s[5] : rx_er_o;
  wire  logic       line_rx_sym_msb_i = line_rx_err_i;
  always #20 ref_clk_i = ~ref_clk_i;
  initial #7 forever #160 lk = ~lk;
  pmp_port u_pmp_port (
    .ref_clk_i            (ref_clk_i),
    .rst_i                (rst_i),
    .addr_i               (addr_i),
    .wdata_i              (wdata_i),
    .wr_i                 (wr_i),
    .rd_i                 (rd_i),
    .rdata_o              (rdata_o),
    .txd_i                (txd_i),
    .tx_symbol_msb_i      (tx_symbol_msb_i),
    .tx_en_i              (tx_en_i),
    .tx_er_i              (tx_er_i),
    .tx_clk_o             (tx_clk_o),
    .tx_word_o            (tx_word_o),
    .tx_word_valid_o      (tx_word_valid_o),
    .line_rxd_i           (line_rxd_i),
    .line_rx_dv_i         (line_rx_dv_i),
    .line_rx_err_i        (line_rx_err_i),
    .line_rx_sym_msb_i    (line_rx_sym_msb_i),
    .rxd_pin_i            (rxd_pin_i),
    .rx_dv_pin_i          (rx_dv_pin_i),
    .rx_er_pin_i          (rx_er_pin_i),
    .rxd_o                (rxd_o),
    .rxd_oe_low_o         (rxd_oe_low_o),
    .rx_dv_o              (rx_dv_o),
    .rx_dv_oe_low_o       (rx_dv_oe_low_o),
    .rx_er_o              (rx_er_o),
    .rx_er_oe_low_o       (rx_er_oe_low_o),
    .irq_out_low_o        (irq_out_low_o),
    .irq_out_low_oe_low_o (irq_out_low_oe_low_o),
    .default_op_mode_o    (default_op_mode_o),
    .mgmt_addr_o          (mgmt_addr_o),
    .reduced_iface_o      (reduced_iface_o)
  );
  pmp_mac_model u_pmp_mac_model (.clk_i(ref_clk_i), .tx_clk_i(tx_clk_o), .link_clk_i(lk),
    .rmii_i(reduced_iface_o), .en_i(m_en), .d_i(m_d), .er_i(m_er), .txd_o(txd_i),
    .msb_o(tx_symbol_msb_i), .en_o(tx_en_i), .er_o(tx_er_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    cyc(1);
    wr_i    <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    cyc(1);
    chk(rdata_o, e);
    rd_i   <= 1'b0;
    cyc(1);
  endtask
  task automatic do_reset(input logic [5:0] v);
    s     <= v;
    cyc(3);
    rst_i <= 1'b1;
    cyc(3);
    chk(default_op_mode_o, 8'h07);
    rst_i <= 1'b0;
    cyc(4);
    chk(reduced_iface_o, v[2]);
    chk(default_op_mode_o, {v[4], v[1:0]});
    chk(mgmt_addr_o, {v[3], v[5], v[1]});
    chk({rx_er_oe_low_o, rx_dv_oe_low_o, rxd_oe_low_o}, {2'b00, v[2], v[2], 2'b00});
    rd_reg(pmp_pkg::ADDR_STRAPS, {1'b0, v[2], v[3], v[5], v[1], v[4], v[1:0]});
  endtask
  task automatic tx_frame(input logic rm, input logic sp, input logic sy, input logic ef);
    logic [4:0] v;
    logic [4:0] x;
    logic       e;
    logic       pc;
    int         n;
    int         nr;
    v = 5'($urandom());
    e = ef | 1'($urandom());
    n = 0;
    nr = 0;
    x = (e && sp && !sy && !rm) ? pmp_pkg::CODE_H : rm ? {3'b000, v[1:0]} :
        sy ? v : {1'b0, v[3:0]};
    cyc(12);
    // reference taken here so the edge count spans exactly sixty intervals
    pc = tx_clk_o;
    m_d  <= v;
    m_er <= e;
    m_en <= 1'b1;
    repeat (60) begin
      cyc(1);
      if (tx_clk_o === 1'b1 && pc === 1'b0) nr++;
      pc = tx_clk_o;
      if (tx_word_valid_o === 1'b1) begin
        n++;
        chk(tx_word_o, x);
      end
    end
    chk(n != 0, 1'b1);
    chk(8'(nr), rm ? 8'h00 :
        8'(60 / (2 * (sp ? pmp_pkg::HALF_100 : pmp_pkg::HALF_10))));
    m_en <= 1'b0;
    cyc(30);
  endtask
  task automatic rx_frame(input logic rm, input logic sp);
    logic [3:0] d;
    for (int i = 0; i < 16; i++) begin
      // preamble dibits, then the start delimiter sent low pair first
      d = i < 4 ? 4'h1 : i == 4 ? 4'h3 : i < 8 ? 4'h2 : 4'($urandom());
      line_rxd_i    <= d;
      line_rx_dv_i  <= 1'b1;
      line_rx_err_i <= (i == 15) ? 1'($urandom()) : 1'b0;
      cyc(1);
      if (i != 7) chk(rxd_o, (rm && !sp && i < 8) ? 4'h0 : rm ? {2'b00, d[1:0]} : d);
    end
    line_rx_dv_i  <= 1'b0;
    line_rx_err_i <= 1'b0;
    cyc(4);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h8c4f));
    cyc(2);
    rst_i <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      do_reset({3'($urandom()), 1'(r), 2'($urandom())});
      for (int k = 0; k < 4; k++) begin
        wr_reg(pmp_pkg::ADDR_CONFIG, 8'(k));
        tx_frame(1'(r), k[0], k[1], 1'b0);
        rx_frame(1'(r), k[0]);
      end
    end
    // interrupt path is checked in mii at 100 mb where a tx error counts
    do_reset(6'h00);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00);
    rd_reg(pmp_pkg::ADDR_CONFIG, 8'h01);
    wr_reg(pmp_pkg::ADDR_IRQ_EN, 8'h00);
    wr_reg(pmp_pkg::ADDR_IRQ_CLR, 8'h0F);
    tx_frame(1'b0, 1'b1, 1'b0, 1'b1);
    rd_reg(pmp_pkg::ADDR_IRQ_STAT, 8'h09);
    rd_reg(pmp_pkg::ADDR_TX_WORD, {3'h0, pmp_pkg::CODE_H});
    chk(irq_out_low_oe_low_o, 1'b1);
    wr_reg(pmp_pkg::ADDR_IRQ_EN, 8'h01);
    chk(irq_out_low_oe_low_o, 1'b0);
    rd_reg(pmp_pkg::ADDR_IRQ_EN, 8'h01);
    wr_reg(pmp_pkg::ADDR_IRQ_CLR, 8'h01);
    chk(irq_out_low_oe_low_o, 1'b1);
    rd_reg(pmp_pkg::ADDR_IRQ_STAT, 8'h08);
    give_verdict();
  end
endmodule
`default_nettype wire
